/* File: srbc_ctrl.sv */
// SDRAM command sequencer with burst, row-held and refresh control.
// Assumes an AHB-Lite master, a same-clock access requester and an
// SDRAM clock that arrives from outside and is sampled here.
// Operation
// RULE_01: One to four precharge states follow all-bank precharge, by count field.
// RULE_02: Refresh cycles use the same precharge count field.
// RULE_03: Write latency skip drops CAS latency cycles from writes.
// RULE_04: With burst on, same-row accesses issue column cycles without activate.
// RULE_05: Software must not enable burst with CAS latency 1 parts.
// RULE_06: Open row stays active across other-space accesses while burst is on.
// RULE_07: Refresh, self-refresh, standby, bus release, burst off, mode set close row.
// RULE_08: Refresh runs only when memory type selects SDRAM space.
// RULE_09: Periodic auto-refresh runs only with refresh enable set.
// RULE_10: Refresh counter counts selected clock, refreshes and restarts on match.
// RULE_11: Counter starts once its clock select is written nonzero.
// RULE_12: Other spaces are held off during refresh; parallel option ignored.
// RULE_13: One to three waits follow refresh precharge, before refresh command.
// RULE_14: One to three waits follow refresh command, before next activate.
// RULE_15: Standby with refresh on issues self-refresh; pending refresh first.
// RULE_16: Standby exit clears self-refresh flag and leaves self-refresh.
// RULE_17: Software keeps standby output hold set when using self-refresh.
// RULE_18: Precharge after self-refresh gains one to seven extra states.
// RULE_19: With all clocks stopped, no refresh occurs.
// RULE_20: Plain standby issues no precharge-all.
// RULE_21: Mode set writes drive the offset from the mode base on MRS.
// RULE_22: Software programs single-write, burst length one mode.
// RULE_23: CAS latency codes one to four insert zero to three cycles.
// RULE_24: Refresh request waits pending until the current bus cycle ends.
`timescale 1ns/1ns
module srbc_ctrl
  import srbc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic mem_req,
  input wire srbc_req_t mem_cmd,
  output logic mem_ack,
  input wire logic ext_busy,
  output logic ext_hold,
  input wire logic standby_req,
  input wire logic bus_release,
  input wire logic clock_stop,
  input wire logic sdram_clk_in,
  output srbc_sd_t sd_o
);
  logic [2:0] acc_r;
  logic [6:0] drc_r;
  logic [11:0] rfc_r;
  logic [7:0] rcnt_r;
  logic [7:0] rcmp_r;
  logic [2:0] casc_r;
  logic self_flag_r;
  logic pend_r;
  logic [11:0] pre_r;
  logic s1_r, s2_r, s3_r;
  logic dph_wr_r;
  logic [7:0] dph_a_r;
  srbc_state_t state_r;
  srbc_op_t op_r;
  logic [3:0] cnt_r;
  logic row_open_r;
  logic [15:0] row_r;
  logic we_r;
  logic [23:0] addr_r;
  srbc_sd_t sd_r;
  logic ack_r;

  function automatic logic [15:0] row_of(input logic [23:0] a,
                                         input logic [2:0] w);
    row_of = 16'(a >> (COL_BITS + int'(w)));
  endfunction : row_of

  function automatic logic presc_tick(input logic [2:0] s,
                                      input logic [11:0] p);
    logic [11:0] m;
    m = ~(12'hFFF << ({1'b0, s, 1'b0} - 5'h02));
    presc_tick = (p & m) == m;
  endfunction : presc_tick

  logic [1:0] tpc, rcw, rlw, cl;
  logic [2:0] mxc, mts, cks, ext;
  logic wls, burst, ref_active, tick, ref_tick, match;
  logic wr_acc, wr_drc, wr_rfc, wr_rcnt, wr_rcmp, wr_waitb;
  logic close_row, go_hit;
  srbc_state_t ref_state;

  assign tpc = acc_r[ACC_TPC_LO +: 2];
  assign wls = acc_r[ACC_WLS];
  assign burst = drc_r[DRC_BE];
  assign mxc = drc_r[DRC_MXC_LO +: 3];
  assign mts = drc_r[DRC_MTS_LO +: 3];
  assign cks = rfc_r[RFC_CKS_LO +: 3];
  assign rcw = rfc_r[RFC_RCW_LO +: 2];
  assign rlw = rfc_r[RFC_RLW_LO +: 2];
  assign ext = rfc_r[RFC_TPCS_LO +: 3];
  // Reserved latency codes fall back to the longest latency.
  assign cl = casc_r[2] ? 2'h3 : casc_r[1:0]; // see RULE_23
  assign ref_active = rfc_r[RFC_ON] &&
                      (mts == MTS_SDRAM || mts == MTS_MODE); // see RULE_08
  // The sequencer freezes while all module clocks are stopped.
  assign tick = s2_r && !s3_r && !clock_stop; // see RULE_19
  assign ref_tick = ref_active && cks != 3'h0 && !clock_stop &&
                    presc_tick(cks, pre_r); // see RULE_09 see RULE_11
  assign wr_acc = dph_wr_r && dph_a_r == OFS_ACCESS;
  assign wr_drc = dph_wr_r && dph_a_r == OFS_DRAM;
  assign wr_rfc = dph_wr_r && dph_a_r == OFS_REFRESH;
  assign wr_rcnt = dph_wr_r && dph_a_r == OFS_RCNT;
  assign wr_rcmp = dph_wr_r && dph_a_r == OFS_RCMP;
  assign wr_waitb = dph_wr_r && dph_a_r == OFS_WAITB;
  assign match = ref_tick && rcnt_r == rcmp_r && !wr_rcnt;
  assign close_row = bus_release ||
                     (wr_drc && !hwdata[DRC_BE]); // see RULE_07
  assign go_hit = mem_req && !standby_req && !pend_r && burst &&
                  row_open_r && !(mts == MTS_MODE && mem_cmd.we) &&
                  row_of(mem_cmd.addr, mxc) == row_r; // see RULE_04
  assign ref_state = (op_r == OP_SELF) ? S_SELF : S_REF;
  // Other external spaces wait for the whole refresh sequence.
  assign ext_hold = state_r != S_IDLE &&
                    (op_r == OP_REF || op_r == OP_SELF); // see RULE_12
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mem_ack = ack_r;
  assign sd_o = sd_r;

  // SDRAM clock synchroniser and edge finder.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= sdram_clk_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Bus address phase capture and read data.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dph_wr_r <= 1'b0;
      dph_a_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      dph_wr_r <= hsel && htrans[1] && hwrite;
      dph_a_r <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        unique case (haddr[7:0])
          OFS_ACCESS: hrdata <= {29'h0, acc_r};
          OFS_DRAM: hrdata <= {25'h0, drc_r};
          OFS_REFRESH: hrdata <= {19'h0, self_flag_r, rfc_r};
          OFS_RCNT: hrdata <= {24'h0, rcnt_r};
          OFS_RCMP: hrdata <= {24'h0, rcmp_r};
          OFS_WAITB: hrdata <= {29'h0, casc_r};
          OFS_STATUS: hrdata <= {30'h0, pend_r, row_open_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software configuration registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= RST_ACCESS;
      drc_r <= RST_DRAM;
      rfc_r <= RST_REFRESH;
      rcmp_r <= RST_RCMP;
      casc_r <= RST_CASCODE;
    end else begin
      if (wr_acc) acc_r <= hwdata[2:0];
      if (wr_drc) drc_r <= hwdata[6:0];
      if (wr_rfc) rfc_r <= hwdata[11:0];
      if (wr_rcmp) rcmp_r <= hwdata[7:0];
      if (wr_waitb) casc_r <= hwdata[2:0];
    end
  end

  // Refresh interval counter and pending request; a new match wins.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_r <= 12'h000;
      rcnt_r <= RST_RCNT;
      pend_r <= 1'b0;
    end else begin
      pre_r <= pre_r + 12'h001;
      if (wr_rcnt) begin
        rcnt_r <= hwdata[7:0];
      end else if (ref_tick) begin
        rcnt_r <= (rcnt_r == rcmp_r) ? 8'h00 : rcnt_r + 8'h01; // see RULE_10
      end
      if (match) begin
        pend_r <= 1'b1; // see RULE_10
      end else if (tick && state_r == S_REF) begin
        pend_r <= 1'b0;
      end
    end
  end

  // Command sequencer, one state per SDRAM clock rising edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      op_r <= OP_ACC;
      cnt_r <= 4'h0;
      row_open_r <= 1'b0;
      row_r <= 16'h0000;
      we_r <= 1'b0;
      addr_r <= 24'h000000;
      sd_r <= '{cke: 1'b1, cmd: CMD_NOP, addr: 16'h0000};
      ack_r <= 1'b0;
      self_flag_r <= 1'b0;
    end else begin
      ack_r <= 1'b0;
      if (close_row) row_open_r <= 1'b0;
      if (tick) begin
        sd_r.cmd <= CMD_NOP;
        unique case (state_r)
          S_IDLE: begin
            if (pend_r && !ext_busy) begin
              // A refresh due at standby entry is served first.
              op_r <= OP_REF; // see RULE_24 see RULE_15
              state_r <= S_PRE;
              cnt_r <= 4'(tpc); // see RULE_02
              sd_r.cmd <= CMD_PALL;
              sd_r.addr <= 16'h0001 << PALL_BIT;
              row_open_r <= 1'b0; // see RULE_07
            end else if (standby_req && !pend_r && ref_active) begin
              op_r <= OP_SELF; // see RULE_15
              state_r <= S_PRE;
              cnt_r <= 4'(tpc);
              sd_r.cmd <= CMD_PALL;
              sd_r.addr <= 16'h0001 << PALL_BIT;
              row_open_r <= 1'b0; // see RULE_07
            end else if (standby_req && !pend_r) begin
              row_open_r <= 1'b0; // see RULE_20 see RULE_07
            end else if (go_hit) begin
              we_r <= mem_cmd.we;
              addr_r <= mem_cmd.addr;
              state_r <= S_COL; // see RULE_04 see RULE_06
            end else if (mem_req && !pend_r && !standby_req) begin
              we_r <= mem_cmd.we;
              addr_r <= mem_cmd.addr;
              op_r <= (mts == MTS_MODE && mem_cmd.we) ? OP_MRS : OP_ACC;
              state_r <= S_PRE;
              cnt_r <= 4'(tpc); // see RULE_01
              sd_r.cmd <= CMD_PALL;
              sd_r.addr <= 16'h0001 << PALL_BIT;
              row_open_r <= 1'b0;
            end
          end
          S_PRE: begin
            if (cnt_r != 4'h0) begin
              cnt_r <= cnt_r - 4'h1; // see RULE_01 see RULE_18
            end else begin
              unique case (op_r)
                OP_ACC: begin
                  state_r <= S_ACT;
                  sd_r.cmd <= CMD_ACT;
                  sd_r.addr <= row_of(addr_r, mxc);
                end
                OP_MRS: begin
                  state_r <= S_MRS; // see RULE_21
                  sd_r.cmd <= CMD_MRS;
                  sd_r.addr <= 16'(addr_r - MODE_BASE);
                end
                OP_EXIT: state_r <= S_IDLE;
                default: begin
                  if (rcw != 2'h0) begin
                    state_r <= S_PREW; // see RULE_13
                    cnt_r <= 4'(rcw) - 4'h1;
                  end else begin
                    state_r <= ref_state;
                    sd_r.cmd <= CMD_REF;
                    sd_r.cke <= op_r != OP_SELF;
                    self_flag_r <= op_r == OP_SELF;
                  end
                end
              endcase
            end
          end
          S_PREW: begin
            if (cnt_r != 4'h0) begin
              cnt_r <= cnt_r - 4'h1; // see RULE_13
            end else begin
              state_r <= ref_state;
              sd_r.cmd <= CMD_REF;
              sd_r.cke <= op_r != OP_SELF; // see RULE_15
              self_flag_r <= op_r == OP_SELF;
            end
          end
          S_REF: begin
            if (rlw != 2'h0) begin
              state_r <= S_POSTW; // see RULE_14
              cnt_r <= 4'(rlw) - 4'h1;
            end else begin
              state_r <= S_IDLE;
            end
          end
          S_POSTW: begin
            if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
            else state_r <= S_IDLE; // see RULE_14
          end
          S_SELF: begin
            if (!standby_req) begin
              self_flag_r <= 1'b0; // see RULE_16
              sd_r.cke <= 1'b1;
              op_r <= OP_EXIT;
              state_r <= S_PRE;
              cnt_r <= 4'(tpc) + 4'(ext); // see RULE_18
            end
          end
          S_ACT: begin
            state_r <= S_COL;
            row_open_r <= 1'b1;
            row_r <= row_of(addr_r, mxc);
          end
          S_COL: begin
            sd_r.cmd <= we_r ? CMD_WR : CMD_RD;
            sd_r.addr <= 16'(addr_r[COL_BITS-1:0]);
            if ((we_r && wls) || cl == 2'h0) begin
              state_r <= S_DATA; // see RULE_03
            end else begin
              state_r <= S_CL; // see RULE_23
              cnt_r <= 4'(cl) - 4'h1;
            end
          end
          S_CL: begin
            if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
            else state_r <= S_DATA;
          end
          S_DATA: begin
            ack_r <= 1'b1;
            state_r <= S_IDLE;
          end
          S_MRS: begin
            ack_r <= 1'b1;
            row_open_r <= 1'b0; // see RULE_07
            state_r <= S_IDLE;
          end
        endcase
      end else if (s2_r && !s3_r) begin
        sd_r.cmd <= CMD_NOP; // see RULE_19
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_pre_done;
    tick && state_r == S_PRE && cnt_r == 4'h0;
  endsequence
  sequence s_self_exit;
    tick && state_r == S_SELF && !standby_req;
  endsequence

  a_pre_load: assert property ($rose(state_r == S_PRE) && op_r == OP_ACC
    |-> cnt_r == 4'(tpc)) else $error("precharge count wrong"); // see RULE_01
  a_pre_count: assert property (tick && state_r == S_PRE && cnt_r != 4'h0
    |=> state_r == S_PRE && cnt_r == $past(cnt_r) - 4'h1)
    else $error("precharge does not count");
  a_ref_pre: assert property ($rose(state_r == S_PRE) && op_r == OP_REF
    |-> cnt_r == 4'(tpc)) else $error("refresh precharge wrong"); // see RULE_02
  a_pre_act: assert property (s_pre_done ##0 op_r == OP_ACC
    |=> state_r == S_ACT && sd_r.cmd == CMD_ACT)
    else $error("activate missing");
  a_wr_skip: assert property (tick && state_r == S_COL && we_r && wls
    |=> state_r == S_DATA) else $error("write latency kept"); // see RULE_03
  a_burst_hit: assert property (tick && state_r == S_IDLE && go_hit
    |=> state_r == S_COL) else $error("burst hit activated"); // see RULE_06
  a_ref_gate: assert property (!ref_active && !pend_r |=> !pend_r)
    else $error("refresh while disabled"); // see RULE_09
  a_cnt_wrap: assert property (match |=> rcnt_r == 8'h00 && pend_r)
    else $error("counter did not restart"); // see RULE_10
  a_ext_hold: assert property (state_r == S_REF |-> ext_hold)
    else $error("other space not held"); // see RULE_12
  a_pre_wait: assert property (s_pre_done ##0 op_r == OP_REF && rcw != 2'h0
    |=> state_r == S_PREW && cnt_r == 4'(rcw) - 4'h1)
    else $error("pre refresh wait wrong"); // see RULE_13
  a_post_wait: assert property (tick && state_r == S_REF && rlw != 2'h0
    |=> state_r == S_POSTW) else $error("post wait missing"); // see RULE_14
  a_self_cke: assert property (state_r == S_SELF |-> !sd_r.cke && self_flag_r)
    else $error("self refresh not held"); // see RULE_15
  a_self_exit: assert property (s_self_exit |=> !self_flag_r &&
    state_r == S_PRE && cnt_r == 4'(tpc) + 4'(ext))
    else $error("self refresh exit wrong"); // see RULE_16
  a_mrs_addr: assert property ($rose(state_r == S_MRS) |-> sd_r.cmd ==
    CMD_MRS && sd_r.addr == 16'(addr_r - MODE_BASE))
    else $error("mode address wrong"); // see RULE_21
endmodule : srbc_ctrl

/* File: srbc_ctrl_tb_top.sv */
// Self-checking bench of the SDRAM refresh and burst controller.
// Assumes the controller answers the register bus with zero waits.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module srbc_ctrl_tb_top
  import srbc_pkg::*;
;
  logic clk, nrst, hsel, hwrite, hreadyout, hresp, mem_req, mem_ack;
  logic ext_busy, ext_hold, standby_req, bus_release, clock_stop, sdram_clk;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  srbc_req_t mem_cmd;
  srbc_sd_t sd_o;
  logic [15:0] n_act, n_ref, n_self, n_pall, mode_val, a, r0;
  logic [7:0] pall_gap, ref_gap, self_gap;
  logic mode_bad, cke_seen, seen;
  int bad_count, checked, tk, t0;

  srbc_ctrl srbc_ctrl_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .ext_busy(ext_busy), .ext_hold(ext_hold),
    .standby_req(standby_req), .bus_release(bus_release),
    .clock_stop(clock_stop), .sdram_clk_in(sdram_clk), .sd_o(sd_o));
  srbc_sdram_model srbc_sdram_model_i (.sdram_clk(sdram_clk), .nrst(nrst),
    .sd(sd_o), .n_act(n_act), .n_ref(n_ref), .n_self(n_self),
    .n_pall(n_pall), .mode_val(mode_val), .pall_gap(pall_gap),
    .ref_gap(ref_gap), .self_gap(self_gap), .mode_bad(mode_bad),
    .cke_seen(cke_seen));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    sdram_clk = 1'b0;
    #7;
    forever #40 sdram_clk = ~sdram_clk;
  end

  function automatic logic [31:0] rf(input int on, ck, rw, lw, ex);
    return 32'(on + (ck << RFC_CKS_LO) + (rw << RFC_RCW_LO)
      + (lw << RFC_RLW_LO) + (ex << RFC_TPCS_LO));
  endfunction : rf
  function automatic logic [31:0] dr(input int be, mx, mt);
    return 32'((be << DRC_BE) + (mx << DRC_MXC_LO) + (mt << DRC_MTS_LO));
  endfunction : dr

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  task automatic ahb(input logic wr, input logic [7:0] ad,
    input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h000000, ad};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 99);
    rd = hrdata;
  endtask : ahb
  task automatic rdchk(input string nm, input logic [7:0] ad,
    input logic [31:0] e);
    ahb(1'b0, ad, 32'h00000000);
    `CHK(nm, e, rd);
  endtask : rdchk
  task automatic acc(input logic we, input logic [23:0] ad);
    int n;
    logic p;
    @(posedge sdram_clk);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_cmd <= '{we: we, addr: ad};
    tk = 0;
    n = 0;
    p = sdram_clk;
    do begin
      @(negedge clk);
      n++;
      if (sdram_clk && !p) tk++;
      p = sdram_clk;
    end while (mem_ack !== 1'b1 && n < 4000);
    `CHK("mem_ack", 1'b1, mem_ack);
    @(posedge clk);
    mem_req <= 1'b0;
  endtask : acc
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (ext_hold === 1'b1) seen = 1'b1;
    end
    @(posedge clk);
  endtask : watch
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("MISMATCH watchdog exp done got timeout");
    give_verdict();
  end

  initial begin
    {nrst, hsel, hwrite, mem_req, ext_busy, standby_req} = '0;
    {bus_release, clock_stop, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    mem_cmd = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdchk("access", OFS_ACCESS, 32'(RST_ACCESS));
    rdchk("dram", OFS_DRAM, 32'(RST_DRAM));
    rdchk("refresh", OFS_REFRESH, 32'(RST_REFRESH));
    rdchk("rcnt", OFS_RCNT, 32'(RST_RCNT));
    rdchk("rcmp", OFS_RCMP, 32'(RST_RCMP));
    rdchk("waitb", OFS_WAITB, 32'(RST_CASCODE));
    ahb(1'b1, 8'h1C, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h1C, 32'h00000000);
    `CHK("hresp", 1'b0, hresp);
    $display("test registers done");
    ahb(1'b1, OFS_DRAM, dr(0, 0, MTS_SDRAM));
    ahb(1'b1, OFS_WAITB, 32'h00000000);
    for (int t = 0; t < 4; t++) begin
      ahb(1'b1, OFS_ACCESS, 32'(t));
      acc(1'b0, 24'h001000);
      `CHK("pall_gap", 8'(t + 1), pall_gap);
    end
    ahb(1'b1, OFS_ACCESS, 32'h00000000);
    // A full read without latency cycles acks four ticks after its precharge.
    t0 = 4;
    for (int c = 0; c < 4; c++) begin
      ahb(1'b1, OFS_WAITB, 32'(c));
      acc(1'b0, 24'h001000);
      `CHK("cas_ticks", t0 + c, tk);
    end
    ahb(1'b1, OFS_ACCESS, 32'h00000004);
    acc(1'b1, 24'h001000);
    `CHK("skip_ticks", t0, tk);
    ahb(1'b1, OFS_ACCESS, 32'h00000000);
    acc(1'b1, 24'h001000);
    `CHK("noskip_ticks", t0 + 3, tk);
    $display("test timing done");
    ahb(1'b1, OFS_WAITB, 32'h00000001);
    ahb(1'b1, OFS_DRAM, dr(1, 0, MTS_SDRAM));
    acc(1'b0, 24'h012345);
    a = n_act;
    acc(1'b0, 24'h0123AB);
    `CHK("burst_hit", a, n_act);
    ext_busy <= 1'b1;
    w(30);
    ext_busy <= 1'b0;
    acc(1'b1, 24'h012301);
    `CHK("row_held", a, n_act);
    acc(1'b0, 24'h045600);
    `CHK("row_miss", a + 16'h0001, n_act);
    for (int k = 0; k < 4; k++) begin
      a = n_act;
      case (k)
        0: begin bus_release <= 1'b1; w(30); bus_release <= 1'b0; end
        1: begin standby_req <= 1'b1; w(100); standby_req <= 1'b0; end
        2: begin
          ahb(1'b1, OFS_DRAM, dr(0, 0, MTS_SDRAM));
          ahb(1'b1, OFS_DRAM, dr(1, 0, MTS_SDRAM));
        end
        default: begin
          ahb(1'b1, OFS_DRAM, dr(1, 0, MTS_MODE));
          acc(1'b1, MODE_BASE + 24'h000220);
          `CHK("mode_val", 16'h0220, mode_val);
          `CHK("mode_bad", 1'b0, mode_bad);
          ahb(1'b1, OFS_DRAM, dr(1, 0, MTS_SDRAM));
        end
      endcase
      acc(1'b0, 24'h045611);
      `CHK("closed_row", a + 16'h0001, n_act);
    end
    ahb(1'b1, OFS_DRAM, dr(1, 1, MTS_SDRAM));
    acc(1'b0, 24'h045600);
    a = n_act;
    acc(1'b0, 24'h045700);
    `CHK("row_width", a, n_act);
    $display("test burst done");
    ahb(1'b1, OFS_DRAM, dr(0, 0, MTS_SDRAM));
    ahb(1'b1, OFS_RCNT, 32'h00000010);
    ahb(1'b1, OFS_RCMP, 32'h00000030);
    ahb(1'b1, OFS_REFRESH, rf(1, 0, 0, 0, 0));
    w(50);
    rdchk("rcnt_stop", OFS_RCNT, 32'h00000010);
    r0 = n_ref;
    ahb(1'b1, OFS_DRAM, dr(0, 0, 0));
    ahb(1'b1, OFS_REFRESH, rf(1, 1, 0, 0, 0) | 32'h00000010);
    w(400);
    `CHK("no_sdram_ref", r0, n_ref);
    ahb(1'b1, OFS_ACCESS, 32'h00000002);
    ahb(1'b1, OFS_DRAM, dr(0, 0, MTS_SDRAM));
    ahb(1'b1, OFS_REFRESH, rf(1, 1, 3, 2, 0));
    w(600);
    `CHK("ref_runs", 1'b1, n_ref > r0);
    `CHK("pre_wait", 8'h06, pall_gap);
    `CHK("post_wait", 8'h04, ref_gap);
    ahb(1'b1, OFS_REFRESH, rf(0, 1, 0, 0, 0));
    w(200);
    r0 = n_ref;
    w(400);
    `CHK("ref_off", r0, n_ref);
    ext_busy <= 1'b1;
    ahb(1'b1, OFS_REFRESH, rf(1, 1, 0, 0, 0) | 32'h00000010);
    w(200);
    r0 = n_ref;
    watch(400);
    `CHK("busy_wait", r0, n_ref);
    `CHK("busy_hold", 1'b0, seen);
    ext_busy <= 1'b0;
    watch(400);
    `CHK("ext_hold", 1'b1, seen);
    `CHK("busy_done", 1'b1, n_ref > r0);
    clock_stop <= 1'b1;
    w(200);
    r0 = n_ref;
    w(400);
    `CHK("clk_stop", r0, n_ref);
    clock_stop <= 1'b0;
    $display("test refresh done");
    ahb(1'b1, OFS_REFRESH, rf(0, 0, 0, 0, 0));
    ahb(1'b1, OFS_ACCESS, 32'h00000000);
    w(200);
    a = n_pall;
    standby_req <= 1'b1;
    w(200);
    `CHK("plain_standby", a, n_pall);
    standby_req <= 1'b0;
    ahb(1'b1, OFS_RCMP, 32'h000000FF);
    ahb(1'b1, OFS_REFRESH, rf(1, 3, 0, 0, 2));
    a = n_self;
    standby_req <= 1'b1;
    w(400);
    `CHK("self_cmd", a + 16'h0001, n_self);
    `CHK("self_cke", 1'b0, cke_seen);
    rdchk("self_flag", OFS_REFRESH, rf(1, 3, 0, 0, 2) | 32'h00001000);
    standby_req <= 1'b0;
    acc(1'b0, 24'h001000);
    `CHK("exit_cke", 1'b1, cke_seen);
    `CHK("self_ext", 8'h04, self_gap);
    rdchk("flag_clr", OFS_REFRESH, rf(1, 3, 0, 0, 2));
    $display("test self refresh done");
    give_verdict();
  end
endmodule : srbc_ctrl_tb_top

/* File: srbc_pkg.sv */
// Shared constants and types of the SDRAM refresh and burst controller.
// Assumes one 250 MHz clock and a 32-bit AHB-Lite register port.
package srbc_pkg;
  localparam logic [7:0] OFS_ACCESS = 8'h00;
  localparam logic [7:0] OFS_DRAM = 8'h04;
  localparam logic [7:0] OFS_REFRESH = 8'h08;
  localparam logic [7:0] OFS_RCNT = 8'h0C;
  localparam logic [7:0] OFS_RCMP = 8'h10;
  localparam logic [7:0] OFS_WAITB = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [2:0] RST_ACCESS = 3'h0;
  localparam logic [6:0] RST_DRAM = 7'h00;
  localparam logic [11:0] RST_REFRESH = 12'h000;
  localparam logic [7:0] RST_RCNT = 8'h00;
  localparam logic [7:0] RST_RCMP = 8'hFF;
  localparam logic [2:0] RST_CASCODE = 3'h7;
  localparam int ACC_TPC_LO = 0;
  localparam int ACC_WLS = 2;
  localparam int DRC_BE = 0;
  localparam int DRC_MXC_LO = 1;
  localparam int DRC_MTS_LO = 4;
  localparam int RFC_ON = 0;
  localparam int RFC_CKS_LO = 1;
  localparam int RFC_PAR = 4;
  localparam int RFC_RCW_LO = 5;
  localparam int RFC_RLW_LO = 7;
  localparam int RFC_TPCS_LO = 9;
  localparam int COL_BITS = 8;
  localparam logic [2:0] MTS_SDRAM = 3'h4;
  localparam logic [2:0] MTS_MODE = 3'h5;
  localparam logic [23:0] MODE_BASE = 24'h400000;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PALL = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam int PALL_BIT = 10;

  typedef struct packed {
    logic we;
    logic [23:0] addr;
  } srbc_req_t;

  typedef struct packed {
    logic cke;
    logic [2:0] cmd;
    logic [15:0] addr;
  } srbc_sd_t;

  typedef enum logic [3:0] {
    S_IDLE, S_PRE, S_PREW, S_REF, S_POSTW, S_ACT, S_COL, S_CL, S_DATA,
    S_MRS, S_SELF
  } srbc_state_t;

  typedef enum logic [2:0] {
    OP_ACC, OP_REF, OP_SELF, OP_MRS, OP_EXIT
  } srbc_op_t;
endpackage : srbc_pkg

/* File: srbc_sdram_model.sv */
// Far-side SDRAM model: samples the command bus on each SDRAM clock rise.
// Assumes the controller settles its command bus well before each rise.
`timescale 1ns/1ns
module srbc_sdram_model
  import srbc_pkg::*;
(
  input wire logic sdram_clk,
  input wire logic nrst,
  input wire srbc_sd_t sd,
  output logic [15:0] n_act,
  output logic [15:0] n_ref,
  output logic [15:0] n_self,
  output logic [15:0] n_pall,
  output logic [15:0] mode_val,
  output logic [7:0] pall_gap,
  output logic [7:0] ref_gap,
  output logic [7:0] self_gap,
  output logic mode_bad,
  output logic cke_seen
);
  logic [7:0] tick_r;
  logic [7:0] pall_t;
  logic [7:0] ref_t;
  logic [7:0] up_t;

  always_ff @(posedge sdram_clk or negedge nrst) begin
    if (!nrst) begin
      {n_act, n_ref, n_self, n_pall, mode_val} <= '0;
      {tick_r, pall_t, ref_t, up_t, pall_gap, ref_gap, self_gap} <= '0;
      mode_bad <= 1'b0;
      cke_seen <= 1'b1;
    end else begin
      tick_r <= tick_r + 8'h01;
      cke_seen <= sd.cke;
      if (sd.cke && !cke_seen) begin
        up_t <= tick_r;
      end
      case (sd.cmd)
        CMD_PALL: begin
          n_pall <= n_pall + 16'h0001;
          pall_t <= tick_r;
          ref_gap <= tick_r - ref_t;
          self_gap <= tick_r - up_t;
        end
        CMD_ACT: begin
          n_act <= n_act + 16'h0001;
          pall_gap <= tick_r - pall_t;
        end
        CMD_REF: begin
          pall_gap <= tick_r - pall_t;
          ref_t <= tick_r;
          if (sd.cke) begin
            n_ref <= n_ref + 16'h0001;
          end else begin
            n_self <= n_self + 16'h0001;
          end
        end
        CMD_MRS: begin
          mode_val <= sd.addr;
          mode_bad <= (sd.addr[2:0] != 3'h0) || !sd.addr[9];
        end
        default: begin
        end
      endcase
    end
  end
endmodule : srbc_sdram_model
